// ===== hw/cam_host.sv
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
// Contract
// RULE_01 - card opens one access session only after application info setup ends
// RULE_02 - host refuses any second concurrent access session
// RULE_03 - once open, host sends access_system_query with tag 0x9F8030
// RULE_04 - card answers query with access_system_report listing 16-bit system numbers
// RULE_05 - both sides keep the session open after the query exchange
// RULE_06 - card sends access_state_notice, tag 0x9F8034, on every state change
// RULE_07 - host processes every access_state_notice it receives
// RULE_08 - five messages; query and request go out, report, answer, notice come in
// RULE_09 - resource id 0x00030042 single stream, 0x00030081 multi stream
// RULE_10 - with several streams each message carries local_transport_stream_id
// RULE_11 - multi stream: one request per stream with its id; host manages capacity
// RULE_12 - any stream filtering by host goes through the PID request exchange
// RULE_13 - card filters control message streams and ties them to components
// RULE_14 - host sends a separate request for every selected program
// RULE_15 - request carries only access descriptors, nothing else from the map table
// RULE_16 - stream-level descriptors override program-level ones for that stream
// RULE_17 - resend request on new program, version change or current/next change
// RULE_18 - request header order: tag, length, action, program, version, flag, info length
// RULE_19 - command code only when info length nonzero; stream entry field layout
// RULE_20 - list actions 0x00 to 0x05 decoded; 0x06 and above reserved
// RULE_21 - card obeys command codes 0x01 to 0x04 as defined
// RULE_22 - decode length field, bound loops by it, drop inconsistent messages
module cam_host import cam_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// session from card
	input wire logic ai_done,
	input wire logic sess_req,
	output logic sess_grant,
	output logic sess_deny,
	// bytes to card
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	// bytes from card
	input wire logic rx_valid,
	input wire logic [7:0] rx_data
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	cam_host_st_t hs_q;
	cam_rx_st_t rxs_q;
	logic pready_q, pslverr_q, grant_q, deny_q, tx_valid_q, open_q, multi_q, resend_q, err_q;
	logic [31:0] prdata_q, rd_val;
	logic [7:0] tx_data_q, act_q, cmd_q, lts_q, st_q, answer_q, notice_q, nsys_q, rx_lts_q;
	logic [15:0] prog_q, sys0_q, t_sys_q, blen_q, bpos_q, cur_len, npos;
	logic [4:0] ver_q, idx_q, tx_len;
	logic cn_q, rd_hit, act_ok, cmd_ok, launch, bad_req, wr_fire, acc, cfg_wr, rx_end, rx_err;
	logic [12:0] pid_q;
	logic [23:0] rx_tag_q;
	logic [1:0] rx_cnt_q;
	logic [103:0] req;
	logic [143:0] fr;

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign sess_grant = grant_q;
	assign sess_deny = deny_q;
	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;

	// ----------------------------------------
	// apb slave, one wait state
	// ----------------------------------------
	assign acc = psel && penable;
	assign wr_fire = acc && pwrite && pready_q;
	assign cfg_wr = wr_fire && hs_q != HS_REQ;

	always_comb begin
		rd_hit = 1'b1;
		case (paddr)
			OFS_CTRL: rd_val = {31'h0000_0000, multi_q};
			OFS_PROG: rd_val = {8'h00, prog_q, act_q};
			OFS_HDR: rd_val = {8'h00, lts_q, cmd_q, 2'b00, cn_q, ver_q};
			OFS_ES: rd_val = {11'h000, pid_q, st_q};
			OFS_STAT: rd_val = {nsys_q, notice_q, answer_q, 2'b00, err_q, resend_q, open_q, hs_q};
			OFS_SYS: rd_val = {8'h00, rx_lts_q, sys0_q};
			OFS_RESID: rd_val = multi_q ? RESID_MULTI : RESID_SINGLE; // RULE_09
			default: begin
				rd_val = REG_RST;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= REG_RST;
		end else if (acc && !pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= !rd_hit;
			prdata_q <= rd_val;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// request fields and resend trigger
	// ----------------------------------------
	assign act_ok = act_q <= ACT_UPDATE; // RULE_20
	assign cmd_ok = cmd_q >= CMD_DESCR && cmd_q <= CMD_NOT_SEL;
	assign launch = hs_q == HS_READY && resend_q && act_ok && cmd_ok; // RULE_14
	assign bad_req = hs_q == HS_READY && resend_q && !(act_ok && cmd_ok); // RULE_20

	always_ff @(posedge clock) begin
		if (rst) begin
			multi_q <= 1'b0;
			{act_q, prog_q} <= 24'h00_0000;
			{ver_q, cn_q, cmd_q, lts_q} <= 22'h00_0000;
			{st_q, pid_q} <= 21'h00_0000;
		end else if (cfg_wr) begin
			case (paddr)
				OFS_CTRL: multi_q <= pwdata[CTRL_MULTI_BIT];
				OFS_PROG: {prog_q, act_q} <= pwdata[23:0];
				OFS_HDR: {lts_q, cmd_q, cn_q, ver_q} <= {pwdata[23:8], pwdata[5:0]};
				OFS_ES: {pid_q, st_q} <= pwdata[20:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			resend_q <= 1'b0;
		end else if (cfg_wr && ((paddr == OFS_CTRL && pwdata[CTRL_SEND_BIT])
				|| (paddr == OFS_PROG && pwdata[23:8] != prog_q)
				|| (paddr == OFS_HDR && pwdata[5:0] != {cn_q, ver_q}))) begin
			resend_q <= 1'b1; // RULE_17
		end else if (launch || bad_req) begin
			resend_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// outgoing frames
	// ----------------------------------------
	// only the command code rides in the info loops; no descriptor and no pid filtering here
	assign req = {act_q, prog_q, 2'b11, ver_q, cn_q, 4'hF, INFO_LEN, cmd_q, // RULE_18 RULE_15
		st_q, 3'b111, pid_q, 4'hF, INFO_LEN, cmd_q}; // RULE_19 RULE_12

	always_comb begin
		if (hs_q == HS_QUERY) begin
			fr = multi_q ? {TAG_QUERY, 8'h01, lts_q, 104'h0} : {TAG_QUERY, 8'h00, 112'h0}; // RULE_03
			tx_len = QUERY_FRAME + {4'h0, multi_q};
		end else begin
			fr = multi_q ? {TAG_REQ, REQ_BODY_LEN + 8'h01, lts_q, req} // RULE_10 RULE_11
				: {TAG_REQ, REQ_BODY_LEN, req, 8'h00}; // RULE_08
			tx_len = REQ_FRAME + {4'h0, multi_q};
		end
	end

	// ----------------------------------------
	// session and transmit sequencer
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			hs_q <= HS_CLOSED;
			open_q <= 1'b0;
			grant_q <= 1'b0;
			deny_q <= 1'b0;
			idx_q <= 5'h00;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
		end else begin
			grant_q <= 1'b0;
			deny_q <= 1'b0;
			case (hs_q)
				HS_QUERY, HS_REQ: begin
					if (!tx_valid_q || tx_ready) begin
						if (idx_q == tx_len) begin
							tx_valid_q <= 1'b0;
							hs_q <= (hs_q == HS_QUERY) ? HS_WAIT : HS_READY;
						end else begin
							tx_valid_q <= 1'b1;
							tx_data_q <= fr[(8'd143 - {idx_q, 3'b000}) -: 8];
							idx_q <= idx_q + 5'h01;
						end
					end
				end
				HS_WAIT: begin
					if (rx_end && !rx_err && rx_tag_q == TAG_REPORT) begin
						hs_q <= HS_READY; // RULE_05
					end
				end
				HS_READY: begin
					if (launch) begin
						hs_q <= HS_REQ;
						idx_q <= 5'h00;
					end
				end
				HS_CLOSED: ;
				default: hs_q <= HS_CLOSED;
			endcase
			if (sess_req) begin
				if (open_q || !ai_done) begin
					deny_q <= 1'b1; // RULE_02
				end else begin
					grant_q <= 1'b1;
					open_q <= 1'b1;
					hs_q <= HS_QUERY; // RULE_03
					idx_q <= 5'h00;
				end
			end
		end
	end

	// ----------------------------------------
	// incoming message parser
	// ----------------------------------------
	assign cur_len = (rxs_q == RX_LEN) ? {8'h00, rx_data}
		: (rxs_q == RX_LEXT) ? {blen_q[7:0], rx_data} : blen_q;
	assign rx_end = rx_valid && ((rxs_q == RX_BODY && bpos_q == blen_q - 16'h0001)
		|| (rxs_q == RX_LEN && rx_data == 8'h00)
		|| (rxs_q == RX_LEXT && rx_cnt_q == 2'h1 && cur_len == 16'h0000)); // RULE_22
	// report body with an odd count of system-number bytes, missing stream id or unknown tag are dropped
	assign rx_err = (rx_tag_q == TAG_REPORT && (cur_len[0] ^ multi_q))
		|| (multi_q && cur_len == 16'h0000)
		|| !(rx_tag_q inside {TAG_REPORT, TAG_ANSWER, TAG_NOTICE}); // RULE_08 RULE_22
	assign npos = bpos_q - {15'h0000, multi_q};

	always_ff @(posedge clock) begin
		if (rst) begin
			rxs_q <= RX_TAG;
			rx_tag_q <= 24'h00_0000;
			rx_cnt_q <= 2'h0;
			blen_q <= 16'h0000;
			bpos_q <= 16'h0000;
			t_sys_q <= 16'h0000;
			rx_lts_q <= 8'h00;
		end else if (rx_valid) begin
			case (rxs_q)
				RX_TAG: begin
					rx_tag_q <= {rx_tag_q[15:0], rx_data};
					rx_cnt_q <= (rx_cnt_q == 2'h2) ? 2'h0 : rx_cnt_q + 2'h1;
					if (rx_cnt_q == 2'h2) begin
						rxs_q <= RX_LEN;
					end
				end
				RX_LEN: begin
					blen_q <= cur_len;
					bpos_q <= 16'h0000;
					if (rx_data == LEN_EXT1 || rx_data == LEN_EXT2) begin
						blen_q <= 16'h0000;
						rx_cnt_q <= rx_data[1:0];
						rxs_q <= RX_LEXT;
					end else begin
						rxs_q <= (rx_data == 8'h00 || rx_data > LEN_SHORT_MAX) ? RX_TAG : RX_BODY;
					end
				end
				RX_LEXT: begin
					blen_q <= cur_len;
					rx_cnt_q <= rx_cnt_q - 2'h1;
					if (rx_cnt_q == 2'h1) begin
						rxs_q <= (cur_len == 16'h0000) ? RX_TAG : RX_BODY;
					end
				end
				RX_BODY: begin
					bpos_q <= bpos_q + 16'h0001;
					if (multi_q && bpos_q == 16'h0000) begin
						rx_lts_q <= rx_data; // RULE_10
					end
					if (npos == 16'h0000) begin
						t_sys_q[15:8] <= rx_data;
					end
					if (npos == 16'h0001) begin
						t_sys_q[7:0] <= rx_data;
					end
					if (rx_end) begin
						rxs_q <= RX_TAG;
					end
				end
				default: rxs_q <= RX_TAG;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			answer_q <= 8'h00;
			notice_q <= 8'h00;
			nsys_q <= 8'h00;
			sys0_q <= 16'h0000;
		end else if (rx_end && !rx_err) begin
			case (rx_tag_q)
				TAG_REPORT: begin
					nsys_q <= 8'((cur_len - {15'h0000, multi_q}) >> 1);
					sys0_q <= (npos == 16'h0001) ? {t_sys_q[15:8], rx_data} : t_sys_q;
				end
				TAG_ANSWER: answer_q <= answer_q + 8'h01;
				TAG_NOTICE: notice_q <= notice_q + 8'h01; // RULE_07
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			err_q <= 1'b0;
		end else if (bad_req || (rx_end && rx_err)
				|| (rx_valid && rxs_q == RX_LEN && rx_data > LEN_EXT2)
				|| (rx_valid && rxs_q == RX_LEN && rx_data == 8'h80)) begin
			err_q <= 1'b1; // RULE_22
		end else if (wr_fire && paddr == OFS_STAT && pwdata[STAT_ERR_BIT]) begin
			err_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_apb_wait;
		psel && penable && !pready_q;
	endsequence
	property p_apb_ans;
		s_apb_wait |=> pready_q ##1 !pready_q;
	endproperty
	a_apb_ans: assert property (p_apb_ans) else $error("apb answer not one wait");
	property p_deny;
		sess_req && open_q |=> deny_q && !grant_q;
	endproperty
	a_deny: assert property (p_deny) else $error("second session not refused"); // RULE_02
	property p_query;
		grant_q |-> hs_q == HS_QUERY ##1 (tx_valid_q && tx_data_q == TAG_QUERY[23:16]);
	endproperty
	a_query: assert property (p_query) else $error("query not started"); // RULE_03
	property p_stay_open;
		open_q |=> open_q;
	endproperty
	a_stay_open: assert property (p_stay_open) else $error("session closed"); // RULE_05
	property p_notice;
		rx_end && !rx_err && rx_tag_q == TAG_NOTICE |=> notice_q == $past(notice_q) + 8'h01;
	endproperty
	a_notice: assert property (p_notice) else $error("notice not counted"); // RULE_07
	property p_resid;
		psel && penable && !pready_q && paddr == OFS_RESID
			|=> prdata_q == (multi_q ? RESID_MULTI : RESID_SINGLE);
	endproperty
	a_resid: assert property (p_resid) else $error("wrong resource id"); // RULE_09
	property p_lts;
		hs_q == HS_REQ && multi_q && tx_valid_q && idx_q == 5'h05 |-> tx_data_q == lts_q;
	endproperty
	a_lts: assert property (p_lts) else $error("stream id missing"); // RULE_10
	property p_badact;
		hs_q == HS_READY && resend_q && act_q > ACT_UPDATE |=> hs_q == HS_READY && err_q;
	endproperty
	a_badact: assert property (p_badact) else $error("reserved action sent"); // RULE_20
	property p_badlen;
		rx_valid && rxs_q == RX_LEN && rx_data > LEN_EXT2 |=> rxs_q == RX_TAG && err_q;
	endproperty
	a_badlen: assert property (p_badlen) else $error("bad length kept"); // RULE_22
endmodule // cam_host

// ===== hw/cam_pkg.sv
package cam_pkg;
	// ----------------------------------------
	// message tags and resource identifiers
	// ----------------------------------------
	localparam logic [23:0] TAG_QUERY = 24'h9F_8030;
	localparam logic [23:0] TAG_REPORT = 24'h9F_8031;
	localparam logic [23:0] TAG_REQ = 24'h9F_8032;
	localparam logic [23:0] TAG_ANSWER = 24'h9F_8033;
	localparam logic [23:0] TAG_NOTICE = 24'h9F_8034;
	localparam logic [31:0] RESID_SINGLE = 32'h0003_0042;
	localparam logic [31:0] RESID_MULTI = 32'h0003_0081;
	// ----------------------------------------
	// list actions, command codes, length field
	// ----------------------------------------
	localparam logic [7:0] ACT_UPDATE = 8'h05;
	localparam logic [7:0] CMD_DESCR = 8'h01;
	localparam logic [7:0] CMD_NOT_SEL = 8'h04;
	localparam logic [7:0] LEN_SHORT_MAX = 8'h7F;
	localparam logic [7:0] LEN_EXT1 = 8'h81;
	localparam logic [7:0] LEN_EXT2 = 8'h82;
	localparam logic [7:0] REQ_BODY_LEN = 8'h0D;
	localparam logic [11:0] INFO_LEN = 12'h001;
	localparam logic [4:0] QUERY_FRAME = 5'h04;
	localparam logic [4:0] REQ_FRAME = 5'h11;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PROG = 8'h04;
	localparam logic [7:0] OFS_HDR = 8'h08;
	localparam logic [7:0] OFS_ES = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_SYS = 8'h14;
	localparam logic [7:0] OFS_RESID = 8'h18;
	localparam int CTRL_MULTI_BIT = 0;
	localparam int CTRL_SEND_BIT = 1;
	localparam int STAT_ERR_BIT = 5;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	// ----------------------------------------
	// states
	// ----------------------------------------
	typedef enum logic [2:0] {HS_CLOSED, HS_QUERY, HS_WAIT, HS_READY, HS_REQ} cam_host_st_t;
	typedef enum logic [1:0] {RX_TAG, RX_LEN, RX_LEXT, RX_BODY} cam_rx_st_t;
endpackage

// ===== verif/cam_card_model.sv
`timescale 1ns/1ps
module cam_card_model import cam_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// session
	output logic ai_done,
	output logic sess_req,
	input wire logic sess_grant,
	input wire logic sess_deny,
	// bytes from host
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	// bytes to host
	output logic rx_valid,
	output logic [7:0] rx_data
);
	logic slow = 1'b0;
	logic rep_due = 1'b0;
	logic [7:0] got[$];
	logic [12:0] ecm_pid = 13'h0000;
	logic descr = 1'b0;
	initial begin
		ai_done = 1'b0;
		sess_req = 1'b0;
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end
	// ----------------------------------------
	// byte sink, single-stream query spotting
	// ----------------------------------------
	always @(posedge clock) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (!rst && tx_valid && tx_ready) begin
			got.push_back(tx_data);
			if (got.size() >= 4 && {got[got.size()-4], got[got.size()-3],
				got[got.size()-2], got[got.size()-1]} == {TAG_QUERY, 8'h00})
				rep_due <= 1'b1;
			// whole request in: the stream entry closes it, its own code rules that stream
			if (got.size() >= 4 && got.size() == int'(got[3]) + 4
				&& {got[0], got[1], got[2]} == TAG_REQ) begin
				ecm_pid <= {got[got.size()-5][4:0], got[got.size()-4]};
				descr <= got[got.size()-1] == CMD_DESCR;
			end
		end
	end
	// ----------------------------------------
	// report, session stays open for good
	// ----------------------------------------
	initial forever begin
		@(posedge clock);
		if (rep_due) begin
			rep_due = 1'b0;
			send({TAG_REPORT, 8'h02, 16'h0B00});
		end
	end
	// one frame: tag, short length, two body bytes
	task send(input logic [47:0] v);
		for (int i = 5; i >= 0; i--) begin
			@(posedge clock);
			rx_valid <= 1'b1;
			rx_data <= v[8*i +: 8];
			@(posedge clock);
			rx_valid <= 1'b0;
			rx_data <= ~v[8*i +: 8];
		end
	endtask
	// ask for the session; normal flow only once ai_done is up
	task open(output logic g, output logic d);
		@(posedge clock);
		sess_req <= 1'b1;
		@(posedge clock);
		sess_req <= 1'b0;
		g = 1'b0;
		d = 1'b0;
		repeat (3) begin
			@(negedge clock);
			g = g | sess_grant;
			d = d | sess_deny;
		end
	endtask
endmodule // cam_card_model

// ===== verif/cam_host_tb_top.sv
`timescale 1ns/1ps
module cam_host_tb_top import cam_pkg::*;;
	logic clock, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic ai_done, sess_req, sess_grant, sess_deny, tx_valid, tx_ready, rx_valid;
	logic [7:0] tx_data, rx_data;
	int err_total = 0;
	int checked = 0;
	cam_host dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ai_done(ai_done), .sess_req(sess_req), .sess_grant(sess_grant),
		.sess_deny(sess_deny), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data));
	cam_card_model card (.clock(clock), .rst(rst), .ai_done(ai_done), .sess_req(sess_req),
		.sess_grant(sess_grant), .sess_deny(sess_deny), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task summarize;
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50)
			err_total++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic ee);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(r & m, x);
		chk({31'h0000_0000, e}, {31'h0000_0000, ee});
	endtask
	task tframe(input logic [143:0] v, input int n);
		int k;
		k = 0;
		while (card.got.size() < n && k < 3000) begin
			@(posedge clock);
			k++;
		end
		repeat (4) @(posedge clock);
		chk(32'(card.got.size()), 32'(n));
		for (int i = 0; i < n; i++)
			chk({24'h00_0000, card.got[i]}, {24'h00_0000, v[8*(n-1-i) +: 8]});
		card.got.delete();
	endtask
	function automatic logic [143:0] req(input logic [7:0] vb);
		return {8'h00, TAG_REQ, 8'h0D, 8'h03, 16'h1234, vb, 8'hF0, 8'h01, 8'h01, 8'h02,
			8'hE1, 8'h01, 8'hF0, 8'h01, 8'h01};
	endfunction
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		rd(OFS_STAT, 32'hFFFF_FFFF, REG_RST, 1'b0);
		rd(OFS_RESID, 32'hFFFF_FFFF, RESID_SINGLE, 1'b0);
		rd(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
	endtask
	task t_session;
		logic g, d;
		int k;
		logic [31:0] r;
		logic e;
		card.open(g, d);
		chk({30'h0000_0000, g, d}, 32'h0000_0001);
		card.ai_done <= 1'b1;
		card.open(g, d);
		chk({30'h0000_0000, g, d}, 32'h0000_0002);
		tframe({112'h0, TAG_QUERY, 8'h00}, 4);
		k = 0;
		r = 32'h0000_0000;
		while (r !== 32'h0100_000B && k < 40) begin
			apb(1'b0, OFS_STAT, 32'h0000_0000, r, e);
			k++;
		end
		rd(OFS_STAT, 32'hFFFF_FFFF, 32'h0100_000B, 1'b0);
		rd(OFS_SYS, 32'hFFFF_FFFF, 32'h0000_0B00, 1'b0);
		card.open(g, d);
		chk({30'h0000_0000, g, d}, 32'h0000_0001);
	endtask
	task t_request;
		card.slow = 1'b1;
		wr(OFS_ES, 32'h0001_0102);
		wr(OFS_HDR, 32'h0000_0100);
		wr(OFS_PROG, 32'h0012_3403);
		tframe(req(8'hC0), 17);
		chk({19'h0_0000, card.ecm_pid}, 32'h0000_0101);
		chk({31'h0000_0000, card.descr}, 32'h0000_0001);
		wr(OFS_HDR, 32'h0000_0125);
		tframe(req(8'hCB), 17);
		wr(OFS_CTRL, 32'h0000_0002);
		tframe(req(8'hCB), 17);
		card.slow = 1'b0;
	endtask
	task t_reserved;
		wr(OFS_PROG, 32'h0012_3506);
		repeat (100) @(posedge clock);
		chk(32'(card.got.size()), 32'h0000_0000);
		rd(OFS_STAT, 32'h0000_0030, 32'h0000_0020, 1'b0);
		wr(OFS_STAT, 32'h0000_0020);
		rd(OFS_STAT, 32'h0000_0020, 32'h0000_0000, 1'b0);
		wr(OFS_PROG, 32'h0012_3403);
		tframe(req(8'hCB), 17);
		wr(OFS_HDR, 32'h0000_0524);
		repeat (40) @(posedge clock);
		chk(32'(card.got.size()), 32'h0000_0000);
		rd(OFS_STAT, 32'h0000_0030, 32'h0000_0020, 1'b0);
		wr(OFS_STAT, 32'h0000_0020);
		wr(OFS_HDR, 32'h0000_0125);
		tframe(req(8'hCB), 17);
	endtask
	task t_rx;
		card.send({TAG_NOTICE, 8'h02, 16'h0001});
		card.send({TAG_ANSWER, 8'h02, 16'h0000});
		rd(OFS_STAT, 32'hFFFF_FFFF, 32'h0101_010B, 1'b0);
		card.send({TAG_NOTICE, 8'h80, 16'h0000});
		rd(OFS_STAT, 32'h0000_0020, 32'h0000_0020, 1'b0);
	endtask
	task t_multi;
		logic [143:0] q;
		logic g, d;
		wr(OFS_HDR, 32'h0007_0125);
		wr(OFS_CTRL, 32'h0000_0003);
		q = req(8'hCB);
		tframe({TAG_REQ, 8'h0E, 8'h07, q[103:0]}, 18);
		rd(OFS_RESID, 32'hFFFF_FFFF, RESID_MULTI, 1'b0);
		// second reset in mid-run, then a multi-stream session
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		rd(OFS_STAT, 32'hFFFF_FFFF, REG_RST, 1'b0);
		wr(OFS_CTRL, 32'h0000_0001);
		wr(OFS_HDR, 32'h0007_0100);
		card.open(g, d);
		chk({30'h0000_0000, g, d}, 32'h0000_0002);
		tframe({104'h0, TAG_QUERY, 8'h01, 8'h07}, 5);
		card.send({TAG_NOTICE, 8'h02, 8'h07, 8'h01});
		rd(OFS_SYS, 32'h00FF_0000, 32'h0007_0000, 1'b0);
		rd(OFS_STAT, 32'hFFFF_FFFF, 32'h0001_000A, 1'b0);
	endtask
	// ----------------------------------------
	// clock, reset, sequence, watchdog
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_reset;
		t_session;
		t_request;
		t_reserved;
		t_rx;
		t_multi;
		summarize;
	end
	initial begin
		#200000;
		err_total++;
		summarize;
	end
endmodule // cam_host_tb_top
